// ### include/dac_serial_pkg.sv
// Shared constants of the serial front end and load control
package dac_serial_pkg;
	// Frame layout
	localparam int FRAME_BITS = 24;
	localparam int DATA_BITS = 20;
	localparam int RW_POS = 23;
	localparam int ADDR_MSB = 22;
	localparam int ADDR_LSB = 20;
	localparam int COUNT_W = 5;
	localparam logic [COUNT_W-1:0] FRAME_BITS_CNT = 5'h18;
	// Register addresses
	localparam logic [2:0] ADDR_DAC = 3'h1;
	localparam logic [2:0] ADDR_CTRL = 3'h2;
	localparam logic [2:0] ADDR_CLEAR = 3'h3;
	// Control field positions
	localparam int CTRL_TWOS_POS = 1;
	localparam int CTRL_W = 20;
	// Reset values
	localparam logic [DATA_BITS-1:0] DAC_RESET = 20'h00000;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 20'h00000;
	localparam logic [DATA_BITS-1:0] CLEAR_RESET = 20'h00000;
	localparam logic [DATA_BITS-1:0] SIGN_FLIP = 20'h80000;
	// Write-frame buffer
	localparam int FIFO_DEPTH = 32;
	// Serial clock limits kept by the host, in MHz
	localparam int SCLK_WRITE_MAX_MHZ = 35;
	localparam int SCLK_READ_MAX_MHZ = 16;
	localparam int SYS_CLK_MHZ = 200;
	// Least system cycles per serial clock period (rounded down)
	localparam int SCLK_WRITE_MIN_CYC = SYS_CLK_MHZ / SCLK_WRITE_MAX_MHZ;
	localparam int SCLK_READ_MIN_CYC = SYS_CLK_MHZ / SCLK_READ_MAX_MHZ;
endpackage

// ### rtl/pin_sync3.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module pin_sync3 #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Pins and clean levels
	input wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] level_out
);
	logic [WIDTH-1:0] stage1_reg;
	logic [WIDTH-1:0] stage2_reg;
	logic [WIDTH-1:0] stage3_reg;
	logic [WIDTH-1:0] level_reg;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			stage1_reg <= INIT;
			stage2_reg <= INIT;
			stage3_reg <= INIT;
		end else begin
			stage1_reg <= pin_in;
			stage2_reg <= stage1_reg;
			stage3_reg <= stage2_reg;
		end
	end

	// A change counts only once stages two and three agree
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			level_reg <= INIT;
		end else begin
			for (int i = 0; i < WIDTH; i++) begin
				if (stage2_reg[i] == stage3_reg[i]) begin
					level_reg[i] <= stage3_reg[i];
				end
			end
		end
	end

	assign level_out = level_reg;
endmodule // pin_sync3
`default_nettype wire

// ### rtl/frame_fifo.sv
// Word FIFO between frame capture and register update
`timescale 1ns/1ps
`default_nettype none
module frame_fifo #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 32
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic flush,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int PTR_W = $clog2(DEPTH);
	localparam logic [PTR_W:0] DEPTH_CNT = (PTR_W+1)'(DEPTH);
	localparam logic [PTR_W-1:0] LAST_IDX = PTR_W'(DEPTH - 1);

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [PTR_W-1:0] wr_ptr_reg;
	logic [PTR_W-1:0] rd_ptr_reg;
	logic [PTR_W:0] count_reg;
	logic push;
	logic pop;

	assign in_ready = (count_reg != DEPTH_CNT);
	assign out_valid = (count_reg != '0);
	assign out_data = mem_reg[rd_ptr_reg];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem_reg[wr_ptr_reg] <= in_data;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
		end else if (flush) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= (wr_ptr_reg == LAST_IDX) ? '0 : wr_ptr_reg + 1'b1;
			end
			if (pop) begin
				rd_ptr_reg <= (rd_ptr_reg == LAST_IDX) ? '0 : rd_ptr_reg + 1'b1;
			end
			if (push && !pop) begin
				count_reg <= count_reg + 1'b1;
			end else if (pop && !push) begin
				count_reg <= count_reg - 1'b1;
			end
		end
	end
endmodule // frame_fifo
`default_nettype wire

// ### rtl/dac_serial_load_control.sv
// Serial front end and output-load control of a 20-bit voltage DAC
`timescale 1ns/1ps
`default_nettype none
module dac_serial_load_control
	import dac_serial_pkg::*;
(
	// System clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Serial link pins
	input wire logic frame_select_n,
	input wire logic serial_clock,
	input wire logic serial_in,
	output logic serial_out,
	output logic serial_out_en,
	// Side-band pins
	input wire logic load_output_n,
	input wire logic clear_to_preset_n,
	input wire logic reset_n,
	// Converter side
	output logic [DATA_BITS-1:0] dac_level,
	output logic twos_coding,
	// Buffer status
	output logic frame_stall
);
	typedef enum logic [1:0] {IDLE, FRAME, CLOSE} link_state_t;

	logic fs_n_s, sclk_s, sdi_s, ld_n_s, clr_n_s, rst_n_s;
	logic sclk_prev_reg, fs_n_prev_reg, ld_n_prev_reg;
	logic sclk_fall, sclk_rise, frame_open, frame_close, load_fall;
	link_state_t state_reg;
	logic [FRAME_BITS-1:0] shift_reg;
	logic [COUNT_W-1:0] bit_count_reg;
	logic [FRAME_BITS-1:0] out_shift_reg;
	logic serial_out_reg;
	logic push_valid;
	logic push_ready;
	logic word_valid;
	logic word_ready;
	logic [FRAME_BITS-1:0] word;
	logic [DATA_BITS-1:0] input_reg;
	logic [DATA_BITS-1:0] dac_reg;
	logic [CTRL_W-1:0] ctrl_reg;
	logic [DATA_BITS-1:0] clear_code_reg;
	logic [FRAME_BITS-1:0] readback_reg;
	logic [DATA_BITS-1:0] dac_level_reg;
	logic dev_reset;
	logic apply;
	logic is_read;
	logic [2:0] word_addr;
	logic [DATA_BITS-1:0] word_data;
	logic [DATA_BITS-1:0] read_data;

	// One synchroniser per pin, each reset to its pin's idle level except the clock, reset high
	// though it idles low, so only the clock edge detector sees a false edge (a fall) after reset
	pin_sync3 #(
		.WIDTH(1),
		.INIT(1'b1)
	) u_sync_select (
		.clk_sys(clk_sys),
		.rst(rst),
		.pin_in(frame_select_n),
		.level_out(fs_n_s)
	);

	pin_sync3 #(
		.WIDTH(1),
		.INIT(1'b1)
	) u_sync_clock (
		.clk_sys(clk_sys),
		.rst(rst),
		.pin_in(serial_clock),
		.level_out(sclk_s)
	);

	pin_sync3 #(
		.WIDTH(1),
		.INIT(1'b0)
	) u_sync_data (
		.clk_sys(clk_sys),
		.rst(rst),
		.pin_in(serial_in),
		.level_out(sdi_s)
	);

	pin_sync3 #(
		.WIDTH(1),
		.INIT(1'b1)
	) u_sync_load (
		.clk_sys(clk_sys),
		.rst(rst),
		.pin_in(load_output_n),
		.level_out(ld_n_s)
	);

	pin_sync3 #(
		.WIDTH(1),
		.INIT(1'b1)
	) u_sync_clear (
		.clk_sys(clk_sys),
		.rst(rst),
		.pin_in(clear_to_preset_n),
		.level_out(clr_n_s)
	);

	pin_sync3 #(
		.WIDTH(1),
		.INIT(1'b1)
	) u_sync_reset (
		.clk_sys(clk_sys),
		.rst(rst),
		.pin_in(reset_n),
		.level_out(rst_n_s)
	);

	assign dev_reset = !rst_n_s;

	// Edge detection on the cleaned pin levels
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			sclk_prev_reg <= 1'b1;
			fs_n_prev_reg <= 1'b1;
			ld_n_prev_reg <= 1'b1;
		end else begin
			sclk_prev_reg <= sclk_s;
			fs_n_prev_reg <= fs_n_s;
			ld_n_prev_reg <= ld_n_s;
		end
	end

	assign sclk_fall = sclk_prev_reg && !sclk_s;
	assign sclk_rise = !sclk_prev_reg && sclk_s;
	assign frame_open = fs_n_prev_reg && !fs_n_s;
	assign frame_close = !fs_n_prev_reg && fs_n_s;
	assign load_fall = ld_n_prev_reg && !ld_n_s;

	// Frame tracking
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state_reg <= IDLE;
		end else if (dev_reset) begin
			state_reg <= IDLE;
		end else begin
			case (state_reg)
				IDLE: begin
					if (frame_open) begin
						state_reg <= FRAME;
					end
				end
				FRAME: begin
					if (frame_close) begin
						state_reg <= CLOSE;
					end
				end
				CLOSE: begin
					// A select that falls again at once is not lost
					if (frame_open) begin
						state_reg <= FRAME;
					end else begin
						state_reg <= IDLE;
					end
				end
				default: begin
					state_reg <= IDLE;
				end
			endcase
		end
	end

	// Input shift register; extra bits keep the last 24
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			shift_reg <= '0;
			bit_count_reg <= '0;
		end else if (dev_reset || frame_open) begin
			shift_reg <= '0;
			bit_count_reg <= '0;
		end else if (state_reg == FRAME && !frame_close && sclk_fall) begin
			shift_reg <= {shift_reg[FRAME_BITS-2:0], sdi_s};
			if (bit_count_reg != FRAME_BITS_CNT) begin
				bit_count_reg <= bit_count_reg + 1'b1;
			end
		end
	end

	// Short frames are dropped; a full buffer drops the word too
	assign push_valid = (state_reg == CLOSE) &&
		(bit_count_reg == FRAME_BITS_CNT);
	assign frame_stall = !push_ready;

	frame_fifo #(
		.WIDTH(FRAME_BITS),
		.DEPTH(FIFO_DEPTH)
	) u_frame_fifo (
		.clk_sys(clk_sys),
		.rst(rst),
		.flush(dev_reset),
		.in_valid(push_valid),
		.in_ready(push_ready),
		.in_data(shift_reg),
		.out_valid(word_valid),
		.out_ready(word_ready),
		.out_data(word)
	);

	// Clear and reset hold the register update stalled
	assign word_ready = !dev_reset && clr_n_s;
	assign apply = word_valid && word_ready;
	assign is_read = word[RW_POS];
	assign word_addr = word[ADDR_MSB:ADDR_LSB];
	assign word_data = word[DATA_BITS-1:0];

	always_comb begin
		read_data = '0;
		if (word_addr == ADDR_DAC) begin
			read_data = dac_reg;
		end else if (word_addr == ADDR_CTRL) begin
			read_data = ctrl_reg;
		end else if (word_addr == ADDR_CLEAR) begin
			read_data = clear_code_reg;
		end
	end

	// Input and DAC registers with load control
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			input_reg <= DAC_RESET;
			dac_reg <= DAC_RESET;
		end else if (dev_reset) begin
			input_reg <= DAC_RESET;
			dac_reg <= DAC_RESET;
		end else if (!clr_n_s) begin
			dac_reg <= clear_code_reg;
		end else if (apply && !is_read && word_addr == ADDR_DAC) begin
			input_reg <= word_data;
			if (!ld_n_s) begin
				dac_reg <= word_data;
			end
		end else if (load_fall) begin
			dac_reg <= input_reg;
		end
	end

	// Control and clear-code registers
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ctrl_reg <= CTRL_RESET;
			clear_code_reg <= CLEAR_RESET;
		end else if (dev_reset) begin
			ctrl_reg <= CTRL_RESET;
			clear_code_reg <= CLEAR_RESET;
		end else if (apply && !is_read) begin
			if (word_addr == ADDR_CTRL) begin
				ctrl_reg <= word_data;
			end else if (word_addr == ADDR_CLEAR) begin
				clear_code_reg <= word_data;
			end
		end
	end

	// Read requests leave their answer for the next frame
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			readback_reg <= '0;
		end else if (dev_reset) begin
			readback_reg <= '0;
		end else if (apply && is_read) begin
			readback_reg <= {word[FRAME_BITS-1:DATA_BITS], read_data};
		end
	end

	// Converter level in straight binary whatever the coding
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			dac_level_reg <= DAC_RESET;
		end else if (dev_reset) begin
			dac_level_reg <= DAC_RESET;
		end else if (ctrl_reg[CTRL_TWOS_POS]) begin
			dac_level_reg <= dac_reg ^ SIGN_FLIP;
		end else begin
			dac_level_reg <= dac_reg;
		end
	end

	assign dac_level = dac_level_reg;
	assign twos_coding = ctrl_reg[CTRL_TWOS_POS];

	// Readback shifter; first bit shows after the first rising edge
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			out_shift_reg <= '0;
			serial_out_reg <= 1'b0;
		end else if (dev_reset) begin
			out_shift_reg <= '0;
			serial_out_reg <= 1'b0;
		end else if (frame_open) begin
			out_shift_reg <= readback_reg;
			serial_out_reg <= 1'b0;
		end else if (state_reg == FRAME && sclk_rise) begin
			serial_out_reg <= out_shift_reg[FRAME_BITS-1];
			out_shift_reg <= {out_shift_reg[FRAME_BITS-2:0], 1'b0};
		end
	end

	assign serial_out = serial_out_reg;
	// Released outside frames so several devices share the line
	assign serial_out_en = (state_reg == FRAME) && !fs_n_s;
endmodule // dac_serial_load_control
`default_nettype wire

// ### verification/dac_serial_load_control_checker.sv
// Port checker of the serial front end and load control
`timescale 1ns/1ps
`default_nettype none
module dac_serial_load_control_checker
	import dac_serial_pkg::*;
(
	// Clocks and link
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic frame_select_n,
	input wire logic serial_clock,
	input wire logic serial_in,
	input wire logic serial_out,
	input wire logic serial_out_en,
	// Side-band and outputs
	input wire logic load_output_n,
	input wire logic clear_to_preset_n,
	input wire logic reset_n,
	input wire logic [DATA_BITS-1:0] dac_level,
	input wire logic twos_coding,
	input wire logic frame_stall
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	// Eight cycles cover the pin synchroniser lag
	en_idle_a: assert property (frame_select_n [*8] |-> !serial_out_en)
		else $error("output enabled outside frame");
	en_frame_a: assert property (!frame_select_n [*8] |-> serial_out_en)
		else $error("output not enabled in frame");
	clear_hold_a: assert property (!clear_to_preset_n [*8] |=> $stable(dac_level))
		else $error("level moved while clear held");
	reset_hold_a: assert property (!reset_n [*8] |-> dac_level == DAC_RESET && !twos_coding)
		else $error("state not at power-on value");
	level_quiet_a: assert property ((load_output_n && clear_to_preset_n && reset_n
		&& $stable(twos_coding)) [*8] |-> $stable(dac_level))
		else $error("level moved without load");
	out_shift_a: assert property (($stable(serial_clock) && !frame_select_n) [*8]
		|=> $stable(serial_out))
		else $error("readback moved without clock rise");
	twos_close_a: assert property ($rose(twos_coding) |-> $past(frame_select_n, 4))
		else $error("control updated inside frame");
	level_frame_a: assert property ((!frame_select_n && clear_to_preset_n && reset_n
		&& $stable(load_output_n)) [*8] |-> $stable(dac_level))
		else $error("level moved inside frame");
	cover property ($rose(twos_coding));
	cover property ($fell(clear_to_preset_n));
	cover property ($fell(load_output_n) && frame_select_n);
endmodule // dac_serial_load_control_checker
bind dac_serial_load_control dac_serial_load_control_checker u_chk (.clk_sys,
	.rst, .frame_select_n, .serial_clock, .serial_in, .serial_out,
	.serial_out_en, .load_output_n, .clear_to_preset_n, .reset_n, .dac_level,
	.twos_coding, .frame_stall);
`default_nettype wire

// ### verification/serial_host_model.sv
// Behavioural serial master driving framed 24-bit words
`timescale 1ns/1ps
`default_nettype none
module serial_host_model (
	// Link pins
	output var logic frame_select_n,
	output var logic serial_clock,
	output var logic serial_in,
	input wire logic serial_out
);
	initial begin
		frame_select_n = 1'b1;
		serial_clock = 1'b0;
		serial_in = 1'b0;
	end
	// 160 ns period keeps below both rate limits; clock idles between frames
	task automatic xfer(input logic [23:0] w, output logic [23:0] r);
		frame_select_n = 1'b0;
		#100;
		for (int i = 23; i >= 0; i--) begin
			serial_in = w[i];
			#40 serial_clock = 1'b1;
			#80 serial_clock = 1'b0;
			r[i] = serial_out;
			#40;
		end
		serial_in = ~serial_in;
		#60 frame_select_n = 1'b1;
		#200;
	endtask
endmodule // serial_host_model
`default_nettype wire

// ### verification/test_dac_serial_load_control.sv
// Self-checking bench of the serial front end and load control
`timescale 1ns/1ps
`default_nettype none
module test_dac_serial_load_control
	import dac_serial_pkg::*;
;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic load_output_n = 1'b0;
	logic clear_to_preset_n = 1'b1;
	logic reset_n = 1'b1;
	logic frame_select_n, serial_clock, serial_in, serial_out, serial_out_en;
	logic sdo_wire, twos_coding, frame_stall;
	logic [DATA_BITS-1:0] dac_level;
	logic [23:0] rd;
	int num_errors = 0;
	int checks_done = 0;
	int cyc = 0;
	always #2.5 clk_sys = ~clk_sys;
	// Released line shows the inverted serial_out level, never the driven one
	assign sdo_wire = serial_out_en ? serial_out : ~serial_out;
	serial_host_model u_host (.frame_select_n(frame_select_n),
		.serial_clock(serial_clock), .serial_in(serial_in),
		.serial_out(sdo_wire));
	dac_serial_load_control u_dut (.clk_sys(clk_sys), .rst(rst),
		.frame_select_n(frame_select_n), .serial_clock(serial_clock),
		.serial_in(serial_in), .serial_out(serial_out),
		.serial_out_en(serial_out_en), .load_output_n(load_output_n),
		.clear_to_preset_n(clear_to_preset_n), .reset_n(reset_n),
		.dac_level(dac_level), .twos_coding(twos_coding),
		.frame_stall(frame_stall));
	task automatic wrap_up;
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input string what, input logic [23:0] seen,
		input logic [23:0] exp);
		checks_done++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wait_sys(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	task automatic put(input logic [2:0] a, input logic [19:0] d);
		u_host.xfer({1'b0, a, d}, rd);
		wait_sys(20);
	endtask
	task automatic t_immediate;
		chk("coding", twos_coding, 24'h0);
		put(ADDR_DAC, 20'h12345);
		chk("level", dac_level, 24'h12345);
	endtask
	task automatic t_deferred;
		load_output_n = 1'b1;
		put(ADDR_DAC, 20'hABCDE);
		chk("held level", dac_level, 24'h12345);
		load_output_n = 1'b0;
		wait_sys(12);
		chk("loaded level", dac_level, 24'hABCDE);
	endtask
	task automatic t_twos_clear;
		put(ADDR_CLEAR, 20'h00010);
		put(ADDR_CTRL, 20'h00002);
		chk("coding", twos_coding, 24'h1);
		chk("twos level", dac_level, 24'h02BCDE);
		clear_to_preset_n = 1'b0;
		wait_sys(20);
		chk("clear level", dac_level, 24'h080010);
		clear_to_preset_n = 1'b1;
		wait_sys(8);
	endtask
	task automatic t_readback;
		u_host.xfer({1'b1, ADDR_CTRL, 20'h00000}, rd);
		u_host.xfer(24'h000000, rd);
		chk("readback", rd[19:0], 24'h00002);
		chk("released", serial_out_en, 24'h0);
	endtask
	task automatic t_reset;
		reset_n = 1'b0;
		wait_sys(12);
		reset_n = 1'b1;
		wait_sys(8);
		chk("reset level", dac_level, 24'h0);
		chk("reset coding", twos_coding, 24'h0);
	endtask
	task automatic t_stall;
		clear_to_preset_n = 1'b0;
		wait_sys(8);
		for (int i = 0; i < FIFO_DEPTH; i++) begin
			u_host.xfer({1'b0, ADDR_DAC, 20'(i)}, rd);
		end
		chk("stall full", frame_stall, 24'h1);
		u_host.xfer({1'b0, ADDR_DAC, 20'hFFFFF}, rd);
		chk("clear kept", dac_level, 24'h0);
		clear_to_preset_n = 1'b1;
		wait_sys(FIFO_DEPTH + 12);
		chk("stall drained", frame_stall, 24'h0);
		chk("drained level", dac_level, 24'h00001F);
	endtask
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 60000) begin
			num_errors++;
			wrap_up();
		end
	end
	initial begin
		wait_sys(12);
		rst = 1'b0;
		wait_sys(8);
		t_immediate();
		t_deferred();
		t_twos_clear();
		t_readback();
		t_reset();
		t_stall();
		wrap_up();
	end
endmodule // test_dac_serial_load_control
`default_nettype wire
